// File: core/ccr_bank.sv
// Card configuration register bank: fixed feature word, driver stage register, APB slave
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Driver stage register is 16 bits, resets to 0x404, host may rewrite it.
// - Driver stage presence is reported by a separate card-specific-info indicator bit.
// - Feature word is 64 bits, fixed at manufacture, read-only to the host.
// - Structure version at 63..60 reads 0; values 1..15 are never returned.
// - Base version field sits at bits 59..56.
// - Version-3 flag at bit 47, set for version 3.00 or later.
// - Version-4 flag at bit 42; extended version field at bits 41..38.
// - Erase 55, security 54..52, widths 51..48, ext security 46..43, reserved 37, commands 36..32.
// - Low 32 bits are manufacturer-owned with no standard meaning.
// - All-zero versions: no CMD6, no CMD8, capacity up to 2GB.
// - Base 1, rest zero: CMD6 but not CMD8, capacity up to 2GB.
// - Base 2, rest zero: CMD6, CMD8 and CMD42 supported.
// - Base 2 with version-3 flag: version 2.00 command set present.
// - Block-count support (command bit 33) forces version 3.00 or later.
// - Version 4: base 2, v3 1, v4 1, extended 0.
// - Versions 5..9: base 2, v3 1, extended 1..5.
// - From version 5, v4 flag mirrors any version-4 function support.
// - Unlisted version combinations are reserved and never reported; one set in FEAT_VALUE reads back and decodes as CCR_VER_RSVD.
// - Extended 5 with boot support also implies fast boot support.
// - Bus width field holds 0101: one-bit and four-bit both supported.
module ccr_bank #(
	parameter logic [63:0] FEAT_VALUE   = ccr_pkg::CCR_FEAT_DEFAULT,
	parameter logic        DRV_IMPL     = 1'b1,
	parameter logic        BOOT_SUPPORT = 1'b0
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [ccr_pkg::CCR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                    pwdata,
	input  wire logic [3:0]                     pstrb,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	output logic      [15:0]                    drv_stage,
	output logic                                drv_impl,
	output logic                                feat_valid
);
	import ccr_pkg::*;

	// ****************************************
	// Fixed feature word
	// ****************************************
	ccr_feat_if fif ();

	logic [63:0] feat_w;
	logic        fast_boot_w;

	// Force the fields the hardware pins down; the rest come from the build value
	always_comb begin
		feat_w = FEAT_VALUE;
		feat_w[CCR_STRUCT_HI:CCR_STRUCT_LO] = CCR_STRUCT_V10;
		feat_w[CCR_BUSW_HI:CCR_BUSW_LO] = CCR_BUSW_REQ;
		feat_w[CCR_RSVD_BIT] = 1'b0;
	end

	assign fif.feat = feat_w;

	ccr_ver_decode u_dec (
		.f (fif.dec)
	);

	// Fast boot goes with boot support on an extended-5 card
	assign fast_boot_w = BOOT_SUPPORT &&
		(feat_w[CCR_EXT_HI:CCR_EXT_LO] == CCR_EXT_V9);

	// ****************************************
	// Decoded status word
	// ****************************************
	logic [31:0] status_w;
	logic        ver3_ok_w;

	assign ver3_ok_w = fif.ver inside {CCR_VER_3_0X, CCR_VER_4_XX, CCR_VER_5_XX,
		CCR_VER_6_XX, CCR_VER_7_XX, CCR_VER_8_XX, CCR_VER_9_XX};

	// Capabilities implied by the reported version
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[CCR_ST_VER_HI:CCR_ST_VER_LO] = fif.ver;
		status_w[CCR_ST_VALID] = fif.valid && (!fif.v3_required || ver3_ok_w);
		status_w[CCR_ST_CMD6] = (fif.ver != CCR_VER_1_01) && (fif.ver != CCR_VER_RSVD);
		status_w[CCR_ST_CMD8] = (fif.ver != CCR_VER_1_01) && (fif.ver != CCR_VER_1_10) &&
			(fif.ver != CCR_VER_RSVD);
		status_w[CCR_ST_CMD42] = status_w[CCR_ST_CMD8];
		status_w[CCR_ST_CAP2G] = (fif.ver == CCR_VER_1_01) || (fif.ver == CCR_VER_1_10);
		status_w[CCR_ST_V3REQ] = fif.v3_required;
		status_w[CCR_ST_FASTBOOT] = fast_boot_w;
	end

	// ****************************************
	// APB slave
	// ****************************************
	logic        setup_w;
	logic        hit_w;
	logic [31:0] rd_w;
	logic [15:0] drv_q;
	logic [15:0] drv_d;
	logic        drv_we_w;

	assign setup_w = psel && !penable;

	// Address decode and read mux
	always_comb begin
		hit_w = 1'b1;
		rd_w  = 32'h0000_0000;
		case (paddr)
			CCR_OFS_FEAT_LO:  rd_w = feat_w[31:0];
			CCR_OFS_FEAT_HI:  rd_w = feat_w[63:32];
			CCR_OFS_DRV:      rd_w = {16'h0000, drv_q};
			CCR_OFS_STATUS:   rd_w = status_w;
			CCR_OFS_CSI_FLAG: rd_w = {31'h0000_0000, DRV_IMPL};
			default:          hit_w = 1'b0;
		endcase
	end

	// Byte-lane merge for the driver stage register
	always_comb begin
		drv_d = drv_q;
		if (pstrb[0]) begin
			drv_d[7:0] = pwdata[7:0];
		end
		if (pstrb[1]) begin
			drv_d[15:8] = pwdata[15:8];
		end
	end

	// Write commits in the access phase, which is always the first
	assign drv_we_w = psel && penable && pwrite && (paddr == CCR_OFS_DRV) && DRV_IMPL;

	// Driver stage register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_q <= CCR_DRV_RESET;
		end else if (drv_we_w) begin
			drv_q <= drv_d;
		end
	end

	// No wait state: answer is raised in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_w;
		end
	end

	// Read data and error registered at setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_w) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_w;
			pslverr <= !hit_w || (pwrite && paddr != CCR_OFS_DRV);
		end
	end

	// Mirror outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_stage  <= CCR_DRV_RESET;
			drv_impl   <= 1'b0;
			feat_valid <= 1'b0;
		end else begin
			drv_stage  <= drv_q;
			drv_impl   <= DRV_IMPL;
			feat_valid <= status_w[CCR_ST_VALID];
		end
	end

endmodule : ccr_bank

// File: core/ccr_pkg.sv
// Package: register map, field layout and version encodings of the card configuration bank
package ccr_pkg;

	// ****************************************
	// Register byte offsets on APB
	// ****************************************
	localparam logic [7:0] CCR_OFS_FEAT_LO  = 8'h00; // Feature word bits 31..0
	localparam logic [7:0] CCR_OFS_FEAT_HI  = 8'h04; // Feature word bits 63..32
	localparam logic [7:0] CCR_OFS_DRV      = 8'h08; // Driver stage register
	localparam logic [7:0] CCR_OFS_STATUS   = 8'h0c; // Decoded version and checks
	localparam logic [7:0] CCR_OFS_CSI_FLAG = 8'h10; // Driver stage implemented indicator
	localparam int         CCR_ADDR_W       = 8;

	// ****************************************
	// Field positions in the 64-bit feature word
	// ****************************************
	localparam int CCR_STRUCT_HI  = 63;
	localparam int CCR_STRUCT_LO  = 60;
	localparam int CCR_BASE_HI    = 59;
	localparam int CCR_BASE_LO    = 56;
	localparam int CCR_ERASE_BIT  = 55;
	localparam int CCR_SEC_HI     = 54;
	localparam int CCR_SEC_LO     = 52;
	localparam int CCR_BUSW_HI    = 51;
	localparam int CCR_BUSW_LO    = 48;
	localparam int CCR_V3_BIT     = 47;
	localparam int CCR_EXSEC_HI   = 46;
	localparam int CCR_EXSEC_LO   = 43;
	localparam int CCR_V4_BIT     = 42;
	localparam int CCR_EXT_HI     = 41;
	localparam int CCR_EXT_LO     = 38;
	localparam int CCR_RSVD_BIT   = 37;
	localparam int CCR_CMDS_HI    = 36;
	localparam int CCR_CMDS_LO    = 32;
	localparam int CCR_CMD23_BIT  = 33;

	// ****************************************
	// Field values and reset values
	// ****************************************
	localparam logic [3:0]  CCR_STRUCT_V10   = 4'h0;
	localparam logic [3:0]  CCR_BUSW_REQ     = 4'h5;
	localparam logic [3:0]  CCR_BASE_V101    = 4'h0;
	localparam logic [3:0]  CCR_BASE_V110    = 4'h1;
	localparam logic [3:0]  CCR_BASE_V200    = 4'h2;
	localparam logic [3:0]  CCR_EXT_MAX      = 4'h5;
	localparam logic [3:0]  CCR_EXT_V9       = 4'h5;
	localparam logic [15:0] CCR_DRV_RESET    = 16'h0404;
	localparam logic [31:0] CCR_MFR_DEFAULT  = 32'h0000_0000; // Arbitrary value
	// Default contents: version 3.0X, 1/4 bit widths, no security, all else zero
	localparam logic [63:0] CCR_FEAT_DEFAULT = 64'h0205_8000_0000_0000;

	// ****************************************
	// Decoded version code
	// ****************************************
	typedef enum logic [3:0] {
		CCR_VER_1_01 = 4'b0000,
		CCR_VER_1_10 = 4'b0001,
		CCR_VER_2_00 = 4'b0010,
		CCR_VER_3_0X = 4'b0011,
		CCR_VER_4_XX = 4'b0100,
		CCR_VER_5_XX = 4'b0101,
		CCR_VER_6_XX = 4'b0110,
		CCR_VER_7_XX = 4'b0111,
		CCR_VER_8_XX = 4'b1000,
		CCR_VER_9_XX = 4'b1001,
		CCR_VER_RSVD = 4'b1111
	} ccr_ver_t;

	// Status word bit positions
	localparam int CCR_ST_VER_LO   = 0;
	localparam int CCR_ST_VER_HI   = 3;
	localparam int CCR_ST_VALID    = 4;
	localparam int CCR_ST_CMD6     = 5;
	localparam int CCR_ST_CMD8     = 6;
	localparam int CCR_ST_CMD42    = 7;
	localparam int CCR_ST_CAP2G    = 8;
	localparam int CCR_ST_V3REQ    = 9;
	localparam int CCR_ST_FASTBOOT = 10;

endpackage : ccr_pkg

// File: core/ccr_feat_if.sv
// Interface: feature word and its decoded version between the bank and the decoder
`timescale 1ns/1ps
interface ccr_feat_if;
	logic [63:0]           feat;
	ccr_pkg::ccr_ver_t     ver;
	logic                  valid;
	logic                  v3_required;

	modport bank (output feat, input ver, input valid, input v3_required);
	modport dec  (input feat, output ver, output valid, output v3_required);
endinterface : ccr_feat_if

// File: core/ccr_ver_decode.sv
// Version decoder: maps the four version fields of the feature word to a version code
`timescale 1ns/1ps
module ccr_ver_decode (
	ccr_feat_if.dec f
);
	import ccr_pkg::*;

	logic [3:0] base_w;
	logic [3:0] ext_w;
	logic       v3_w;
	logic       v4_w;

	// Field slices
	assign base_w = f.feat[CCR_BASE_HI:CCR_BASE_LO];
	assign ext_w  = f.feat[CCR_EXT_HI:CCR_EXT_LO];
	assign v3_w   = f.feat[CCR_V3_BIT];
	assign v4_w   = f.feat[CCR_V4_BIT];

	// Version combinations; anything not listed decodes as reserved
	always_comb begin
		f.ver = CCR_VER_RSVD;
		if (base_w == CCR_BASE_V101 && !v3_w && !v4_w && ext_w == 4'h0) begin
			f.ver = CCR_VER_1_01;
		end else if (base_w == CCR_BASE_V110 && !v3_w && !v4_w && ext_w == 4'h0) begin
			f.ver = CCR_VER_1_10;
		end else if (base_w == CCR_BASE_V200 && !v3_w && !v4_w && ext_w == 4'h0) begin
			f.ver = CCR_VER_2_00;
		end else if (base_w == CCR_BASE_V200 && v3_w && !v4_w && ext_w == 4'h0) begin
			f.ver = CCR_VER_3_0X;
		end else if (base_w == CCR_BASE_V200 && v3_w && v4_w && ext_w == 4'h0) begin
			f.ver = CCR_VER_4_XX;
		end else if (base_w == CCR_BASE_V200 && v3_w && ext_w != 4'h0 && ext_w <= CCR_EXT_MAX) begin
			f.ver = ccr_ver_t'(ext_w + 4'h4);
		end
	end

	// Structure version must be 1.0 and the combination must be listed
	assign f.valid = (f.ver != CCR_VER_RSVD) &&
		(f.feat[CCR_STRUCT_HI:CCR_STRUCT_LO] == CCR_STRUCT_V10);

	// Fast-block-count support asks for version 3.00 or later
	assign f.v3_required = f.feat[CCR_CMD23_BIT];

endmodule : ccr_ver_decode

// File: testbench/ccr_bank_sva.sv
// Checker: APB timing and register contents of the card configuration bank
`timescale 1ns/1ps
module ccr_bank_sva #(
	parameter logic DRV_IMPL = 1'b1
) (
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready, pslverr, drv_impl, feat_valid,
	input wire logic [15:0] drv_stage
);
	logic acc, drv_wr;
	// Completed transfer and completed driver stage write
	assign acc    = psel && penable && pready;
	assign drv_wr = acc && pwrite && paddr == 8'h08;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready wider than one cycle");
	a_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer in access");
	a_hi_fields: assert property (acc && !pwrite && paddr == 8'h04 |->
		prdata[31:28] == 4'h0 && prdata[19:16] == 4'h5) else $error("bad fixed fields");
	a_rsvd_bit: assert property (acc && !pwrite && paddr == 8'h04 |-> !prdata[5])
		else $error("reserved bit set");
	a_ro_err: assert property (acc && pwrite && paddr inside {8'h00, 8'h04} |-> pslverr)
		else $error("read-only write not refused");
	a_drv_err: assert property (drv_wr |-> !pslverr) else $error("driver write refused");
	a_drv_follow: assert property (drv_wr && pstrb == 4'hf |-> ##2
		{16'h0000, drv_stage} == ($past(pwdata, 2) & 32'h0000ffff)) else $error("driver value lost");
	a_drv_hold: assert property ($changed(drv_stage) |-> $past(drv_wr, 2))
		else $error("driver stage changed unasked");
	a_flags_out: assert property ($past(presetn) |-> drv_impl == DRV_IMPL && feat_valid)
		else $error("flag outputs wrong");
	a_csi_read: assert property (acc && !pwrite && paddr == 8'h10 |-> prdata[0] == DRV_IMPL)
		else $error("indicator bit wrong");
endmodule : ccr_bank_sva

// File: testbench/ccr_host_model.sv
// Partner model: host controller reaching the bank over APB
`timescale 1ns/1ps
module ccr_host_model (
	input wire logic        pclk, pready, pslverr,
	input wire logic [31:0] prdata,
	output logic            psel, penable, pwrite,
	output logic [7:0]      paddr,
	output logic [31:0]     pwdata,
	output logic [3:0]      pstrb
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// Host reads the version from the base field, not the structure field
	function automatic logic [3:0] base_of(input logic [31:0] hi);
		return hi[27:24];
	endfunction : base_of
	// One transfer; held until pready is sampled, released lines show the inverse
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable, paddr, pwdata} <= {1'b0, 1'b0, ~a, ~d};
	endtask : xfer
endmodule : ccr_host_model

// File: testbench/ccr_bank_test.sv
// Testbench: map, reset values and access rules of the card configuration bank
`timescale 1ns/1ps
module ccr_bank_test;
	import ccr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, drv_impl, feat_valid, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] drv_stage;
	int          err_count, n_checks;
	ccr_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	ccr_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drv_stage(drv_stage), .drv_impl(drv_impl), .feat_valid(feat_valid));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task test_done;
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task t_reset;
		host.xfer(1'b0, CCR_OFS_DRV, 32'h0, 4'h0, rd, er);
		chk(rd, 32'h0000_0404);
		chk({31'h0, drv_impl}, 32'h1);
		host.xfer(1'b0, CCR_OFS_CSI_FLAG, 32'h0, 4'h0, rd, er);
		chk(rd & 32'h1, 32'h1);
		$display("reset test done");
	endtask : t_reset
	task t_feat;
		host.xfer(1'b0, CCR_OFS_FEAT_LO, 32'h0, 4'h0, rd, er);
		chk(rd, CCR_FEAT_DEFAULT[31:0]);
		host.xfer(1'b0, CCR_OFS_FEAT_HI, 32'h0, 4'h0, rd, er);
		chk(rd, 32'h0205_8000);
		chk({28'h0, host.base_of(rd)}, 32'h2);
		chk({31'h0, rd[1]}, 32'h0);
		chk({31'h0, feat_valid}, 32'h1);
		$display("feature test done");
	endtask : t_feat
	task t_ro;
		logic [7:0] ofs[3];
		ofs = '{CCR_OFS_FEAT_LO, CCR_OFS_FEAT_HI, CCR_OFS_STATUS};
		for (int i = 0; i < 3; i++) begin
			host.xfer(1'b1, ofs[i], 32'hffff_ffff, 4'hf, rd, er);
			chk({31'h0, er}, 32'h1);
		end
		t_feat();
	endtask : t_ro
	task t_drv;
		host.xfer(1'b1, CCR_OFS_DRV, 32'hffff_beef, 4'hf, rd, er);
		chk({31'h0, er}, 32'h0);
		repeat (2) @(posedge pclk);
		chk({16'h0, drv_stage}, 32'h0000_beef);
		host.xfer(1'b1, CCR_OFS_DRV, 32'h0000_1200, 4'h2, rd, er);
		host.xfer(1'b0, CCR_OFS_DRV, 32'h0, 4'h0, rd, er);
		chk(rd, 32'h0000_12ef);
		$display("driver test done");
	endtask : t_drv
	// Reset in mid-run brings the driver stage register back to its default
	task t_rst2;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({16'h0, drv_stage}, 32'h0000_0404);
		chk({31'h0, drv_impl}, 32'h0);
		presetn <= 1'b1;
		host.xfer(1'b0, CCR_OFS_DRV, 32'h0, 4'h0, rd, er);
		chk(rd, 32'h0000_0404);
		$display("second reset test done");
	endtask : t_rst2
	task t_misc;
		host.xfer(1'b0, 8'h14, 32'h0, 4'h0, rd, er);
		chk({rd[30:0], er}, 32'h1);
		host.xfer(1'b0, CCR_OFS_STATUS, 32'h0, 4'h0, rd, er);
		chk(rd & 32'h0000_06ff, 32'h0000_00f3);
		$display("status test done");
	endtask : t_misc
	initial begin
		presetn = 1'b0;
		err_count = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		chk({16'h0, drv_stage}, {16'h0, CCR_DRV_RESET});
		presetn <= 1'b1;
		t_reset();
		t_feat();
		t_ro();
		t_drv();
		t_rst2();
		t_misc();
		test_done();
	end
	// Cuts a hang short
	initial begin
		repeat (2000) @(posedge pclk);
		err_count++;
		test_done();
	end
endmodule : ccr_bank_test
bind ccr_bank ccr_bank_sva #(.DRV_IMPL(DRV_IMPL)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .drv_impl(drv_impl), .feat_valid(feat_valid), .drv_stage(drv_stage));
